// >>> rtl/tgpio_port.sv
// Pin control for the third general-purpose pin and the shared port register.
// Assumes same-clock modem status inputs, asynchronous pin levels and chip select,
// and pin 0/1 function codes supplied by their own configuration registers.
//
// Overview of operation
// - Pin two function from config bits 4:0
// - Drive strength kept in config bits 7:6
// - Pull-up only when enabled and digital input
// - Codes 0-2: reset, wake-up, low battery
// - Code 3 direct input, code 10 output
// - Codes 4-6: falling, rising, change interrupts
// - Code 7 analog input, 14 reference out
// - Data clock, transmit data in, receive data
// - Code 17 is retransmission request input
// - Codes 18 and 21 show transmit, receive state
// - Codes 19 and 22 show buffer almost-full
// - Codes 23 and 24 drive antenna switches
// - Codes 25-28 preamble, sync, clear channel
// - Code 29 high, unassigned codes low
// - Port bits 6:4 show interrupt status
// - Interrupt request on data-out when deselected
// - Direct output pins follow port bits 2:0
// - Direct input pins read back sampled level
// - Port bit 7 reserved, read-only
`timescale 1ns/1ns
`default_nettype none
module tgpio_port (
	input  wire logic                         clock,        // 20 MHz system clock
	input  wire logic                         reset,        // Synchronous reset, high
	input  wire logic                         enable,       // Clock enable, freezes all state
	// Register port
	input  wire logic [tgpio_pkg::ADDR_W-1:0] reg_addr,     // Register address
	input  wire logic [tgpio_pkg::DATA_W-1:0] reg_wdata,    // Write data
	input  wire logic                         reg_write,    // Write strobe
	input  wire logic                         reg_read,     // Read strobe
	output logic      [tgpio_pkg::DATA_W-1:0] reg_rdata,    // Read data, cycle after strobe
	// Pin function codes of the other two pins
	input  wire logic [4:0]                   pin0_function_select, // Pin zero code
	input  wire logic [4:0]                   pin1_function_select, // Pin one code
	// Pin levels, asynchronous
	input  wire logic                         gp_pin_zero_in,  // Pin zero level
	input  wire logic                         gp_pin_one_in,   // Pin one level
	input  wire logic                         gp_pin_two_in,   // Pin two level
	// Pin two drive
	output logic                              gp_pin_two_out,  // Pin two output value
	output logic                              gp_pin_two_oe,   // Pin two output enable
	output logic                              pin2_pullup_on,  // Internal pull-up connected
	output logic      [1:0]                   pin2_drive_strength, // Driver strength
	output logic                              pin2_adc_connect,  // Pin to converter input
	output logic                              pin2_vref_connect, // Reference onto pin
	output logic                              tx_mod_data,     // Transmit data from pin
	output logic                              retx_request,    // Retransmission request
	// Direct output values for pins zero and one
	output logic      [1:0]                   pin01_direct_value, // Bits for pins 1:0
	output logic      [2:0]                   pin_irq_status,  // Interrupt status per pin
	// Modem status sources, same clock
	input  wire logic                         por_state,       // Power-on reset active
	input  wire logic                         wakeup_timer_expired, // Wake-up timer done
	input  wire logic                         battery_low,     // Below threshold
	input  wire logic                         data_clock,      // Tx/rx data clock
	input  wire logic                         rx_data,         // Received data
	input  wire logic                         tx_state,        // Transmit state
	input  wire logic                         rx_state,        // Receive state
	input  wire logic                         tx_almost_full,  // Tx buffer almost full
	input  wire logic                         rx_almost_full,  // Rx buffer almost full
	input  wire logic                         antenna1_switch, // Diversity switch 1
	input  wire logic                         antenna2_switch, // Diversity switch 2
	input  wire logic                         preamble_valid,  // Valid preamble
	input  wire logic                         preamble_invalid, // Invalid preamble
	input  wire logic                         sync_detected,   // Sync word found
	input  wire logic                         clear_channel,   // Clear channel
	// Serial data-out sharing
	input  wire logic                         irq_request_n,   // Interrupt request, low
	input  wire logic                         chip_select_n,   // Serial select pin, low
	input  wire logic                         spi_sdo_data,    // Serial engine data out
	input  wire logic                         spi_sdo_oe,      // Serial engine drive
	output logic                              sdo_out,         // Data-out pin value
	output logic                              sdo_oe           // Data-out pin enable
);
	typedef struct packed {
		logic [7:0] cfg2;
		logic [2:0] dio;
		logic       itsdo;
		logic [2:0] status;
		logic [7:0] rdata;
	} tgpio_port_state_t;

	tgpio_port_state_t state_reg;
	tgpio_port_state_t state_next;

	logic [3:0] sync_lv;
	logic [2:0] pin_level;
	logic       select_idle;
	logic [4:0] func2;
	logic [2:0] irq_event;
	logic [2:0] irq_mode;
	logic [2:0] din_mode;
	logic [4:0] mode_of [3];
	logic       hit_cfg;
	logic       hit_port;
	logic [2:0] dio_view;

	// Pin levels and chip select pass two flops before use
	tgpio_sync #(.WIDTH(4)) u_sync (
		.clock    (clock),
		.reset    (reset),
		.enable   (enable),
		.async_in ({chip_select_n, gp_pin_two_in, gp_pin_one_in, gp_pin_zero_in}),
		.sync_out (sync_lv)
	);
	assign pin_level   = sync_lv[2:0];
	assign select_idle = sync_lv[3];

	assign func2      = state_reg.cfg2[tgpio_pkg::FUNC_MSB:tgpio_pkg::FUNC_LSB];
	assign mode_of[0] = pin0_function_select;
	assign mode_of[1] = pin1_function_select;
	assign mode_of[2] = func2;

	// One edge detector per pin
	for (genvar i = 0; i < 3; i++) begin : g_edge
		tgpio_edge u_edge (
			.clock       (clock),
			.reset       (reset),
			.enable      (enable),
			.level       (pin_level[i]),
			.mode        (mode_of[i]),
			.event_pulse (irq_event[i])
		);
		assign irq_mode[i] = tgpio_pkg::tgpio_is_irq(mode_of[i]);
		assign din_mode[i] = (mode_of[i] == tgpio_pkg::F_DIRECT_IN);
		// Direct inputs read the pin, everything else the written bit
		assign dio_view[i] = din_mode[i] ? pin_level[i] : state_reg.dio[i];
	end

	assign hit_cfg  = (reg_addr == tgpio_pkg::PIN2_CFG_OFFSET);
	assign hit_port = (reg_addr == tgpio_pkg::PORT_OFFSET);

	// Register writes, status capture and read data
	always_comb begin
		state_next = state_reg;
		if (reg_write && hit_cfg) begin
			state_next.cfg2 = reg_wdata;
		end
		if (reg_write && hit_port) begin
			// Status and reserved bits are not writable
			state_next.dio   = reg_wdata[tgpio_pkg::DIO_MSB:tgpio_pkg::DIO_LSB];
			state_next.itsdo = reg_wdata[tgpio_pkg::ITSDO_BIT];
		end
		// Read clears status; a new event in the same cycle wins
		if (reg_read && hit_port) begin
			state_next.status = '0;
		end
		state_next.status = (state_next.status & irq_mode) | irq_event;
		if (reg_read) begin
			if (hit_cfg) begin
				state_next.rdata = state_reg.cfg2;
			end else if (hit_port) begin
				state_next.rdata = {1'b0, state_reg.status, state_reg.itsdo, dio_view};
			end else begin
				state_next.rdata = 8'h00; // Unmapped reads return zero
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_reg.cfg2   <= tgpio_pkg::PIN2_CFG_RESET;
			state_reg.dio    <= tgpio_pkg::DIO_RESET;
			state_reg.itsdo  <= tgpio_pkg::ITSDO_RESET;
			state_reg.status <= 3'h0;
			state_reg.rdata  <= 8'h00;
		end else if (enable) begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata           = state_reg.rdata;
	assign pin2_drive_strength = state_reg.cfg2[tgpio_pkg::DRV_MSB:tgpio_pkg::DRV_LSB];
	assign pin01_direct_value  = state_reg.dio[1:0];
	assign pin_irq_status      = state_reg.status;

	// Pull-up only meaningful while the pin is a digital input
	assign pin2_pullup_on = state_reg.cfg2[tgpio_pkg::PUP_BIT]
		&& tgpio_pkg::tgpio_is_dig_in(func2);
	assign pin2_adc_connect  = (func2 == tgpio_pkg::F_ADC_IN);
	assign pin2_vref_connect = (func2 == tgpio_pkg::F_VREF_OUT);
	assign tx_mod_data  = (func2 == tgpio_pkg::F_TX_DATA_IN) && pin_level[2];
	assign retx_request = (func2 == tgpio_pkg::F_RETX_REQ) && pin_level[2];

	// Pin two output multiplexer; reserved test codes fall to ground
	always_comb begin
		gp_pin_two_oe  = 1'b1;
		gp_pin_two_out = 1'b0;
		case (func2)
			tgpio_pkg::F_POR:        gp_pin_two_out = por_state;
			tgpio_pkg::F_WAKEUP:     gp_pin_two_out = wakeup_timer_expired;
			tgpio_pkg::F_BATT_LOW:   gp_pin_two_out = battery_low;
			tgpio_pkg::F_DIRECT_IN,
			tgpio_pkg::F_IRQ_FALL,
			tgpio_pkg::F_IRQ_RISE,
			tgpio_pkg::F_IRQ_CHANGE,
			tgpio_pkg::F_ADC_IN,
			tgpio_pkg::F_VREF_OUT,
			tgpio_pkg::F_TX_DATA_IN,
			tgpio_pkg::F_RETX_REQ:   gp_pin_two_oe  = 1'b0;
			tgpio_pkg::F_DIRECT_OUT: gp_pin_two_out = state_reg.dio[2];
			tgpio_pkg::F_DATA_CLK:   gp_pin_two_out = data_clock;
			tgpio_pkg::F_RX_DATA:    gp_pin_two_out = rx_data;
			tgpio_pkg::F_TX_STATE:   gp_pin_two_out = tx_state;
			tgpio_pkg::F_RX_STATE:   gp_pin_two_out = rx_state;
			tgpio_pkg::F_TX_AFULL:   gp_pin_two_out = tx_almost_full;
			tgpio_pkg::F_RX_AFULL:   gp_pin_two_out = rx_almost_full;
			tgpio_pkg::F_ANT1:       gp_pin_two_out = antenna1_switch;
			tgpio_pkg::F_ANT2:       gp_pin_two_out = antenna2_switch;
			tgpio_pkg::F_PRE_VALID:  gp_pin_two_out = preamble_valid;
			tgpio_pkg::F_PRE_BAD:    gp_pin_two_out = preamble_invalid;
			tgpio_pkg::F_SYNC_DET:   gp_pin_two_out = sync_detected;
			tgpio_pkg::F_CCA:        gp_pin_two_out = clear_channel;
			tgpio_pkg::F_VDD:        gp_pin_two_out = 1'b1;
			default:                 gp_pin_two_out = 1'b0;
		endcase
	end

	// Data-out carries the interrupt request only while deselected
	always_comb begin
		if (state_reg.itsdo && select_idle) begin
			sdo_out = irq_request_n;
			sdo_oe  = 1'b1;
		end else begin
			sdo_out = spi_sdo_data;
			sdo_oe  = spi_sdo_oe;
		end
	end

	// Checks
	a_func_write: assert property (@(posedge clock) disable iff (reset)
		(enable && reg_write && hit_cfg) |=> (func2 == $past(reg_wdata[4:0])))
		else $error("function field did not take written value");

	a_drive_write: assert property (@(posedge clock) disable iff (reset)
		(enable && reg_write && hit_cfg) |=> (pin2_drive_strength == $past(reg_wdata[7:6])))
		else $error("drive strength did not take written value");

	a_pullup_gate: assert property (@(posedge clock) disable iff (reset)
		pin2_pullup_on |-> (state_reg.cfg2[5] && !gp_pin_two_oe))
		else $error("pull-up on while pin not a digital input");

	a_vdd_code: assert property (@(posedge clock) disable iff (reset)
		(func2 == 5'h1D) |-> (gp_pin_two_oe && gp_pin_two_out))
		else $error("constant high code not driving high");

	a_test_low: assert property (@(posedge clock) disable iff (reset)
		(func2 inside {5'h08, 5'h0B, 5'h1E, 5'h1F}) |-> (gp_pin_two_oe && !gp_pin_two_out))
		else $error("unassigned code not driving low");

	a_direct_drive: assert property (@(posedge clock) disable iff (reset)
		(enable && reg_write && hit_port && func2 == 5'h0A && !(reg_write && hit_cfg))
		|=> (gp_pin_two_out == $past(reg_wdata[2])))
		else $error("direct output not following written bit");

	a_status_hold: assert property (@(posedge clock) disable iff (reset)
		(enable && reg_write && hit_port && irq_mode == 3'h7)
		|=> ((state_reg.status & $past(state_reg.status)) == $past(state_reg.status)))
		else $error("port write disturbed interrupt status");

	a_event_sets: assert property (@(posedge clock) disable iff (reset)
		(irq_event[2]) |=> state_reg.status[2])
		else $error("interrupt event lost");

	a_reserved_zero: assert property (@(posedge clock) disable iff (reset)
		(enable && reg_read && hit_port) |=> !reg_rdata[7])
		else $error("reserved bit read as one");

	a_dio_read: assert property (@(posedge clock) disable iff (reset)
		(enable && reg_read && hit_port && func2 == 5'h03) |=> (reg_rdata[2] == $past(pin_level[2])))
		else $error("direct input read not pin level");

	a_sdo_irq: assert property (@(posedge clock) disable iff (reset)
		(state_reg.itsdo && select_idle) |-> (sdo_oe && sdo_out == irq_request_n))
		else $error("interrupt request missing on data-out");

	a_por_code: assert property (@(posedge clock) disable iff (reset)
		(func2 == 5'h00) |-> (gp_pin_two_oe && gp_pin_two_out == por_state))
		else $error("reset code not showing reset state");

	a_batt_code: assert property (@(posedge clock) disable iff (reset)
		(func2 == 5'h02) |-> (gp_pin_two_oe && gp_pin_two_out == battery_low))
		else $error("battery code not showing low battery");

	a_input_float: assert property (@(posedge clock) disable iff (reset)
		(func2 == 5'h03) |-> !gp_pin_two_oe)
		else $error("direct input code drives the pin");

	a_irq_float: assert property (@(posedge clock) disable iff (reset)
		(func2 inside {5'h04, 5'h05, 5'h06}) |-> !gp_pin_two_oe)
		else $error("interrupt input code drives the pin");

	a_analog_route: assert property (@(posedge clock) disable iff (reset)
		(func2 == 5'h07) |-> (pin2_adc_connect && !pin2_vref_connect && !gp_pin_two_oe))
		else $error("converter input not routed");

	a_vref_route: assert property (@(posedge clock) disable iff (reset)
		(func2 == 5'h0E) |-> (pin2_vref_connect && !pin2_adc_connect && !gp_pin_two_oe))
		else $error("reference output not routed");

	a_data_clock: assert property (@(posedge clock) disable iff (reset)
		(func2 == 5'h0F) |-> (gp_pin_two_oe && gp_pin_two_out == data_clock))
		else $error("data clock not on pin");

	a_rx_data: assert property (@(posedge clock) disable iff (reset)
		(func2 == 5'h14) |-> (gp_pin_two_oe && gp_pin_two_out == rx_data))
		else $error("received data not on pin");

	a_retx_idle: assert property (@(posedge clock) disable iff (reset)
		(func2 != 5'h11) |-> !retx_request)
		else $error("retransmission request outside its code");

	a_tx_state: assert property (@(posedge clock) disable iff (reset)
		(func2 == 5'h12) |-> (gp_pin_two_oe && gp_pin_two_out == tx_state))
		else $error("transmit state not on pin");

	a_rx_afull: assert property (@(posedge clock) disable iff (reset)
		(func2 == 5'h16) |-> (gp_pin_two_oe && gp_pin_two_out == rx_almost_full))
		else $error("receive almost-full not on pin");

	a_ant_two: assert property (@(posedge clock) disable iff (reset)
		(func2 == 5'h18) |-> (gp_pin_two_oe && gp_pin_two_out == antenna2_switch))
		else $error("second antenna switch not on pin");

	a_cca_code: assert property (@(posedge clock) disable iff (reset)
		(func2 == 5'h1C) |-> (gp_pin_two_oe && gp_pin_two_out == clear_channel))
		else $error("clear channel not on pin");

	a_read_clear: assert property (@(posedge clock) disable iff (reset)
		(enable && reg_read && hit_port && irq_event == 3'h0) |=> (pin_irq_status == 3'h0))
		else $error("port read did not clear status");

	a_status_mask: assert property (@(posedge clock) disable iff (reset)
		(enable && !irq_mode[2]) |=> !pin_irq_status[2])
		else $error("status set while pin not an interrupt source");

endmodule // tgpio_port
`default_nettype wire

// >>> rtl/tgpio_pkg.sv
// Package for the transceiver pin-control block: register map, field
// positions, reset values and the pin function codes.
// Assumes an 8-bit register port with a 7-bit address.
package tgpio_pkg;

	// Register bus shape
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [6:0] PIN2_CFG_OFFSET = 7'h0D;
	localparam logic [6:0] PORT_OFFSET     = 7'h0E;

	// Pin function configuration fields
	localparam int FUNC_LSB  = 0;
	localparam int FUNC_MSB  = 4;
	localparam int PUP_BIT   = 5;
	localparam int DRV_LSB   = 6;
	localparam int DRV_MSB   = 7;

	// Port register fields
	localparam int DIO_LSB    = 0;
	localparam int DIO_MSB    = 2;
	localparam int ITSDO_BIT  = 3;
	localparam int STAT_LSB   = 4;
	localparam int STAT_MSB   = 6;
	localparam int RSVD_BIT   = 7;

	// Reset values
	localparam logic [7:0] PIN2_CFG_RESET = 8'h00;
	localparam logic [2:0] DIO_RESET      = 3'h0;
	localparam logic       ITSDO_RESET    = 1'b0;

	// Pin function codes
	localparam logic [4:0] F_POR        = 5'h00;
	localparam logic [4:0] F_WAKEUP     = 5'h01;
	localparam logic [4:0] F_BATT_LOW   = 5'h02;
	localparam logic [4:0] F_DIRECT_IN  = 5'h03;
	localparam logic [4:0] F_IRQ_FALL   = 5'h04;
	localparam logic [4:0] F_IRQ_RISE   = 5'h05;
	localparam logic [4:0] F_IRQ_CHANGE = 5'h06;
	localparam logic [4:0] F_ADC_IN     = 5'h07;
	localparam logic [4:0] F_DIRECT_OUT = 5'h0A;
	localparam logic [4:0] F_VREF_OUT   = 5'h0E;
	localparam logic [4:0] F_DATA_CLK   = 5'h0F;
	localparam logic [4:0] F_TX_DATA_IN = 5'h10;
	localparam logic [4:0] F_RETX_REQ   = 5'h11;
	localparam logic [4:0] F_TX_STATE   = 5'h12;
	localparam logic [4:0] F_TX_AFULL   = 5'h13;
	localparam logic [4:0] F_RX_DATA    = 5'h14;
	localparam logic [4:0] F_RX_STATE   = 5'h15;
	localparam logic [4:0] F_RX_AFULL   = 5'h16;
	localparam logic [4:0] F_ANT1       = 5'h17;
	localparam logic [4:0] F_ANT2       = 5'h18;
	localparam logic [4:0] F_PRE_VALID  = 5'h19;
	localparam logic [4:0] F_PRE_BAD    = 5'h1A;
	localparam logic [4:0] F_SYNC_DET   = 5'h1B;
	localparam logic [4:0] F_CCA        = 5'h1C;
	localparam logic [4:0] F_VDD        = 5'h1D;

	// Pin acts as an external interrupt source
	function automatic logic tgpio_is_irq(input logic [4:0] code);
		return (code == F_IRQ_FALL) || (code == F_IRQ_RISE) || (code == F_IRQ_CHANGE);
	endfunction

	// Pin acts as any digital input
	function automatic logic tgpio_is_dig_in(input logic [4:0] code);
		return (code == F_DIRECT_IN) || tgpio_is_irq(code)
			|| (code == F_TX_DATA_IN) || (code == F_RETX_REQ);
	endfunction

endpackage

// >>> rtl/tgpio_sync.sv
// Two-stage synchroniser for pin levels.
// Assumes the inputs are asynchronous to clock; stage one is read only by stage two.
`timescale 1ns/1ns
`default_nettype none
module tgpio_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,   // System clock
	input  wire logic             reset,   // Synchronous reset, high
	input  wire logic             enable,  // Clock enable
	input  wire logic [WIDTH-1:0] async_in, // Pin levels
	output logic      [WIDTH-1:0] sync_out  // Synchronised levels
);
	initial begin
		if (WIDTH < 1) $error("tgpio_sync: WIDTH must be at least 1");
	end

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} tgpio_sync_state_t;

	tgpio_sync_state_t state_reg;
	tgpio_sync_state_t state_next;

	// Shift the two stages
	always_comb begin
		state_next        = state_reg;
		state_next.stage1 = async_in;
		state_next.stage2 = state_reg.stage1;
	end

	// Register, frozen while enable is low
	always_ff @(posedge clock) begin
		if (reset) begin
			state_reg <= '0;
		end else if (enable) begin
			state_reg <= state_next;
		end
	end

	assign sync_out = state_reg.stage2;
endmodule // tgpio_sync
`default_nettype wire

// >>> rtl/tgpio_edge.sv
// Edge detector for one pin configured as an external interrupt source.
// Assumes a synchronised level and a function code on the same clock.
`timescale 1ns/1ns
`default_nettype none
module tgpio_edge (
	input  wire logic       clock,  // System clock
	input  wire logic       reset,  // Synchronous reset, high
	input  wire logic       enable, // Clock enable
	input  wire logic       level,  // Synchronised pin level
	input  wire logic [4:0] mode,   // Pin function code
	output logic            event_pulse // One-cycle interrupt event
);
	typedef struct packed {
		logic prev;
		logic primed;
	} tgpio_edge_state_t;

	tgpio_edge_state_t state_reg;
	tgpio_edge_state_t state_next;
	logic              fell;
	logic              rose;

	// Primed flag stops a false edge straight after reset
	always_comb begin
		state_next        = state_reg;
		state_next.prev   = level;
		state_next.primed = 1'b1;
		fell = state_reg.primed && state_reg.prev && !level;
		rose = state_reg.primed && !state_reg.prev && level;
		case (mode)
			tgpio_pkg::F_IRQ_FALL:   event_pulse = enable && fell;
			tgpio_pkg::F_IRQ_RISE:   event_pulse = enable && rose;
			tgpio_pkg::F_IRQ_CHANGE: event_pulse = enable && (fell || rose);
			default:                 event_pulse = 1'b0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_reg <= '0;
		end else if (enable) begin
			state_reg <= state_next;
		end
	end
endmodule // tgpio_edge
`default_nettype wire

// >>> tb/tgpio_pins.sv
// Model of the circuits outside the three pins.
// Assumes the outside is a weak source that gives way to the block's driver.
`timescale 1ns/1ns
`default_nettype none
module tgpio_pins (
	input  wire logic [2:0] level,      // Levels the outside offers
	input  wire logic       two_out,    // Block value on pin two
	input  wire logic       two_oe,     // Block drives pin two
	input  wire logic       two_pullup, // Internal pull-up on pin two
	output logic      [2:0] pin         // Resolved pin levels
);
	// Block driver wins; an undriven pin with pull-up reads high
	assign pin = {two_oe ? two_out : (two_pullup ? 1'b1 : level[2]), level[1:0]};
endmodule // tgpio_pins
`default_nettype wire

// >>> tb/tgpio_port_tb_top.sv
// Self-checking bench for the pin-control block, one task per scenario.
// Assumes the pin model in tgpio_pins.sv; enable is held high throughout.
`timescale 1ns/1ns
`default_nettype none
module tgpio_port_tb_top;
	logic        clock, reset, reg_write, reg_read, csn, irqn, sdod, sdoe;
	logic        p2o, p2e, pup, adc, vref, txm, retx, sdo_out, sdo_oe;
	logic [6:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata;
	logic [4:0]  c0, c1;
	logic [2:0]  lvl, pin, irq_st;
	logic [1:0]  drv, d01;
	logic [14:0] st;
	int          num_errors, samples_checked;
	// Modem status codes in the order of the st bits
	localparam logic [4:0] SRC [15] = '{tgpio_pkg::F_POR, tgpio_pkg::F_WAKEUP,
		tgpio_pkg::F_BATT_LOW, tgpio_pkg::F_DATA_CLK, tgpio_pkg::F_RX_DATA,
		tgpio_pkg::F_TX_STATE, tgpio_pkg::F_RX_STATE, tgpio_pkg::F_TX_AFULL,
		tgpio_pkg::F_RX_AFULL, tgpio_pkg::F_ANT1, tgpio_pkg::F_ANT2,
		tgpio_pkg::F_PRE_VALID, tgpio_pkg::F_PRE_BAD, tgpio_pkg::F_SYNC_DET, tgpio_pkg::F_CCA};

	tgpio_pins ext (.level(lvl), .two_out(p2o), .two_oe(p2e), .two_pullup(pup), .pin(pin));
	tgpio_port DUT (.clock(clock), .reset(reset), .enable(1'b1), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .pin0_function_select(c0), .pin1_function_select(c1),
		.gp_pin_zero_in(pin[0]), .gp_pin_one_in(pin[1]), .gp_pin_two_in(pin[2]),
		.gp_pin_two_out(p2o), .gp_pin_two_oe(p2e), .pin2_pullup_on(pup),
		.pin2_drive_strength(drv), .pin2_adc_connect(adc), .pin2_vref_connect(vref),
		.tx_mod_data(txm), .retx_request(retx), .pin01_direct_value(d01),
		.pin_irq_status(irq_st), .por_state(st[0]), .wakeup_timer_expired(st[1]),
		.battery_low(st[2]), .data_clock(st[3]), .rx_data(st[4]), .tx_state(st[5]),
		.rx_state(st[6]), .tx_almost_full(st[7]), .rx_almost_full(st[8]),
		.antenna1_switch(st[9]), .antenna2_switch(st[10]), .preamble_valid(st[11]),
		.preamble_invalid(st[12]), .sync_detected(st[13]), .clear_channel(st[14]),
		.irq_request_n(irqn), .chip_select_n(csn), .spi_sdo_data(sdod),
		.spi_sdo_oe(sdoe), .sdo_out(sdo_out), .sdo_oe(sdo_oe));

	// Free-running 20 MHz clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Let n edges pass, then sample settled outputs
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// One-cycle strobes; read data are taken after the edge that takes the read
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a; reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask

	task automatic t_reset();
		rdc(7'h0D, 8'h00);
		rdc(7'h0E, 8'h00);
		wr(7'h20, 8'hFF);
		rdc(7'h20, 8'h00);
		rdc(7'h0D, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_cfg();
		wr(7'h0D, 8'hE3);
		rdc(7'h0D, 8'hE3);
		step(1);
		chk({6'h00, drv}, 8'h03);
		chk({7'h00, pup}, 8'h01);
		wr(7'h0D, 8'h6A);
		step(1);
		chk({6'h00, drv}, 8'h01);
		chk({7'h00, pup}, 8'h00);
		$display("test config done");
	endtask

	// Every code except 8 to 13, with two opposite status patterns
	task automatic t_codes();
		logic [4:0] c;
		logic       e;
		for (int p = 0; p < 2; p++) begin
			wr(7'h0E, {5'h00, p[0], 2'h0});
			@(posedge clock) begin st <= p[0] ? 15'h2AAA : 15'h5555; lvl <= {3{p[0]}}; end
			for (int k = 0; k < 32; k++) begin
				c = k[4:0];
				if (c >= 5'h08 && c <= 5'h0D) continue;
				wr(7'h0D, {3'h0, c});
				step(4);
				e = (c == tgpio_pkg::F_VDD) || (c == tgpio_pkg::F_DIRECT_OUT && p[0]);
				for (int s = 0; s < 15; s++) if (SRC[s] == c) e = st[s];
				chk({7'h00, adc}, {7'h00, c == 5'h07});
				chk({7'h00, vref}, {7'h00, c == 5'h0E});
				chk({7'h00, txm}, {7'h00, c == 5'h10 && p[0]});
				chk({7'h00, retx}, {7'h00, c == 5'h11 && p[0]});
				if (c inside {5'h03, 5'h04, 5'h05, 5'h06, 5'h10, 5'h11}) begin
					chk({7'h00, p2e}, 8'h00);
				end else if (c != 5'h07 && c != 5'h0E) begin
					chk({6'h00, p2e, p2o}, {6'h00, 1'b1, e});
				end
			end
		end
		$display("test codes done");
	endtask

	task automatic t_direct();
		@(posedge clock) begin c0 <= tgpio_pkg::F_DIRECT_IN; c1 <= tgpio_pkg::F_DIRECT_OUT; lvl <= 3'b000; end
		wr(7'h0D, 8'h0A);
		wr(7'h0E, 8'hF7);
		step(1);
		chk({6'h00, d01}, 8'h03);
		chk({6'h00, p2e, p2o}, 8'h03);
		wr(7'h0D, 8'h23);
		step(4);
		rdc(7'h0E, 8'h06);
		wr(7'h0D, 8'h03);
		@(posedge clock) lvl <= 3'b001;
		step(4);
		rdc(7'h0E, 8'h03);
		$display("test direct done");
	endtask

	task automatic t_irq();
		@(posedge clock) begin
			c0 <= tgpio_pkg::F_IRQ_RISE; c1 <= tgpio_pkg::F_IRQ_CHANGE; lvl <= 3'b110;
		end
		wr(7'h0D, 8'h04);
		step(6);
		// Pin one rose while in change mode, so its status bit is set
		rdc(7'h0E, 8'h27);
		@(posedge clock) lvl <= 3'b001;
		step(6);
		chk({5'h00, irq_st}, 8'h07);
		rdc(7'h0E, 8'h77);
		rdc(7'h0E, 8'h07);
		@(posedge clock) lvl <= 3'b110;
		step(6);
		rdc(7'h0E, 8'h27);
		$display("test interrupt done");
	endtask

	task automatic t_sdo();
		wr(7'h0E, 8'h08);
		rdc(7'h0E, 8'h08);
		@(posedge clock) begin csn <= 1'b1; irqn <= 1'b0; sdod <= 1'b1; sdoe <= 1'b0; end
		step(3);
		chk({6'h00, sdo_out, sdo_oe}, 8'h01);
		@(posedge clock) irqn <= 1'b1;
		step(1);
		chk({6'h00, sdo_out, sdo_oe}, 8'h03);
		@(posedge clock) csn <= 1'b0;
		step(3);
		chk({6'h00, sdo_out, sdo_oe}, 8'h02);
		wr(7'h0E, 8'h00);
		@(posedge clock) csn <= 1'b1;
		step(3);
		chk({6'h00, sdo_out, sdo_oe}, 8'h02);
		$display("test data-out done");
	endtask

	// Bound on the whole run, in case a scenario hangs
	initial begin
		#1000000;
		num_errors++;
		end_sim();
	end

	// Main sequence
	initial begin
		num_errors = 0; samples_checked = 0; reset = 1'b1;
		reg_write = 1'b0; reg_read = 1'b0; reg_addr = 7'h00; reg_wdata = 8'h00;
		c0 = 5'h00; c1 = 5'h00; lvl = 3'b000; st = 15'h0000;
		csn = 1'b1; irqn = 1'b1; sdod = 1'b0; sdoe = 1'b0;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		t_reset();
		t_cfg();
		t_codes();
		t_direct();
		t_irq();
		t_sdo();
		end_sim();
	end
endmodule // tgpio_port_tb_top
`default_nettype wire
